//--- bench/byte_alu_branch_execute_tb.sv
module byte_alu_branch_execute_tb
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic kind; logic [15:0] val;} note_s;
  localparam logic [INSTR_W-1:0] OPCS [8] = '{OPC_ADD, OPC_ADDC, OPC_ASR, OPC_BCLR, OPC_BTSC, OPC_JMPK, OPC_JMPW,
                                              14'h0000};
  localparam logic [INSTR_W-1:0] MSKS [8] = '{MASK_BYTE, MASK_BYTE, MASK_BYTE, MASK_BIT, MASK_BIT, MASK_JMPK,
                                              MASK_FULL, MASK_FULL};
  logic               clock = 1'b0;
  logic               rst_b = 1'b0;
  logic [INSTR_W-1:0] instrWord;
  logic               instrValid, wregLoadEn, fileWrEn, carryFlag, digit_carry_flag, zeroFlag, pcLoad, discardNext;
  logic [PC_W-1:0]    pcCurrent, pcTarget, mTgt;
  logic [DATA_W-1:0]  fileRdData, wregLoadData, fileWrData, wreg, mW;
  logic [DATA_W-1:0]  mirror [128];
  logic [FADDR_W-1:0] fileAddr;
  logic               mC, mDigitCarry, mZ, drop;
  logic [31:0]        rng;
  note_s              notes [$];
  int                 mismatches, checks, cycles;

  byte_alu_branch_execute dut_u (.clock(clock), .rst_b(rst_b), .instrWord(instrWord), .instrValid(instrValid),
    .pcCurrent(pcCurrent), .fileRdData(fileRdData), .wregLoadEn(wregLoadEn), .wregLoadData(wregLoadData),
    .fileAddr(fileAddr), .fileWrEn(fileWrEn), .fileWrData(fileWrData), .wreg(wreg), .carryFlag(carryFlag),
    .digit_carry_flag(digit_carry_flag), .zeroFlag(zeroFlag), .pcLoad(pcLoad), .pcTarget(pcTarget),
    .discardNext(discardNext));
  data_mem_model mem_u (.clock(clock), .fileAddr(fileAddr), .fileWrEn(fileWrEn), .fileWrData(fileWrData),
    .fileRdData(fileRdData));

  always #4 clock = ~clock;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chkState;
    checks++;
    if ({wreg, carryFlag, digit_carry_flag, zeroFlag} !== {mW, mC, mDigitCarry, mZ})
    begin
      mismatches++;
      $display("mismatch at %0t: state %h flags %b%b%b", $time, wreg, carryFlag, digit_carry_flag, zeroFlag);
    end
  endtask : chkState

  task automatic chkNote(input logic kind, input logic [15:0] val);
    note_s n;
    checks++;
    n = (notes.size() > 0) ? notes.pop_front() : 17'h1FFFF;
    if (n !== {kind, val})
    begin
      mismatches++;
      $display("mismatch at %0t: event %h expected %h", $time, {kind, val}, n);
    end
  endtask : chkNote

  // reference of one presented instruction; a flushed slot has no effect at all
  task automatic model(input logic [INSTR_W-1:0] iw, input logic [PC_W-1:0] pc, input logic ld,
                       input logic [7:0] ldv);
    logic [8:0] s;
    logic [7:0] f, r;
    logic       cin, wr, wW;
    f = mirror[iw[6:0]];
    cin = ((iw & MASK_BYTE) == OPC_ADDC) & mC;
    wr = 1'b0;
    wW = 1'b0;
    r = 8'h00;
    if (drop)
    begin
      drop = 1'b0;
      return;
    end
    if ((iw & MASK_BYTE) == OPC_ADD || (iw & MASK_BYTE) == OPC_ADDC)
    begin
      s = {1'b0, mW} + {1'b0, f} + {8'h00, cin};
      mDigitCarry = (5'(mW[3:0]) + 5'(f[3:0]) + 5'(cin)) > 5'h0F;
      r = s[7:0];
      mC = s[8];
      mZ = (r == 8'h00);
      wr = iw[DEST_POS];
      wW = !iw[DEST_POS];
    end
    else if ((iw & MASK_BYTE) == OPC_ASR)
    begin
      r = {f[7], f[7:1]};
      mC = f[0];
      mZ = (r == 8'h00);
      wr = iw[DEST_POS];
      wW = !iw[DEST_POS];
    end
    else if ((iw & MASK_BIT) == OPC_BCLR)
    begin
      r = f & ~(8'h01 << iw[9:7]);
      wr = 1'b1;
    end
    else if ((iw & MASK_BIT) == OPC_BTSC && !f[iw[9:7]])
    begin
      notes.push_back({1'b1, 1'b0, mTgt});
      drop = 1'b1;
    end
    else if ((iw & MASK_JMPK) == OPC_JMPK || iw == OPC_JMPW)
    begin
      mTgt = pc + 15'h0001 + ((iw == OPC_JMPW) ? {7'h00, mW} : {{6{iw[8]}}, iw[8:0]});
      notes.push_back({1'b1, 1'b1, mTgt});
      drop = 1'b1;
    end
    if (wr)
    begin
      mirror[iw[6:0]] = r;
      notes.push_back({1'b0, 1'b0, iw[6:0], r});
    end
    if (wW)
      mW = r;
    else if (ld)
      mW = ldv;
  endtask : model

  task automatic step(input logic [INSTR_W-1:0] iw, input logic [PC_W-1:0] pc, input logic ld,
                      input logic [7:0] ldv);
    @(posedge clock);
    instrWord <= iw;
    pcCurrent <= pc;
    wregLoadEn <= ld & !drop;
    wregLoadData <= ldv;
    instrValid <= 1'b1;
    #1;
    chkState;
    model(iw, pc, ld & !drop, ldv);
  endtask : step

  // results that appear at the outputs are matched against the oldest note
  always @(negedge clock)
  begin
    if (rst_b && fileWrEn !== 1'b0)
      chkNote(1'b0, {1'b0, fileAddr, fileWrData});
    if (rst_b && discardNext !== 1'b0)
      chkNote(1'b1, {pcLoad, pcTarget});
  end

  // hang guard, far above the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      complete_run;
    end
  end

  initial
  begin
    {instrWord, instrValid, pcCurrent, wregLoadEn, wregLoadData} = '0;
    {mW, mC, mDigitCarry, mZ, drop, mTgt} = '0;
    rng = 32'hA6F6DEE3;
    for (int i = 0; i < 128; i++)
      mirror[i] = 8'(i * 37 + 5);
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    // branch range ends, with program counter wrap
    step(14'h3300, 15'h0000, 1'b1, 8'hF0);
    step(14'h0000, 15'h0001, 1'b0, 8'h00);
    step(14'h32FF, 15'h7FFF, 1'b0, 8'h00);
    step(14'h0000, 15'h0000, 1'b0, 8'h00);
    step(OPC_JMPW, 15'h7F80, 1'b0, 8'h00);
    for (int i = 0; i < 600; i++)
    begin
      rng = xs(rng);
      step(OPCS[rng[2:0]] | (rng[27:14] & ~MSKS[rng[2:0]]), rng[30:16], rng[31], rng[11:4]);
    end
    step(14'h0000, 15'h0000, 1'b0, 8'h00);
    step(14'h0000, 15'h0000, 1'b0, 8'h00);
    checks++;
    if (notes.size() != 0)
    begin
      mismatches++;
      $display("mismatch at %0t: %0d results never appeared", $time, notes.size());
    end
    complete_run;
  end
endmodule : byte_alu_branch_execute_tb

//--- bench/data_mem_model.sv
module data_mem_model
  import exec_pkg::*;
(
  input  wire logic               clock,
  input  wire logic [FADDR_W-1:0] fileAddr,
  input  wire logic               fileWrEn,
  input  wire logic [DATA_W-1:0]  fileWrData,
  output logic      [DATA_W-1:0]  fileRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [128];
  // fixed fill, mirrored by the bench
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i * 37 + 5);
  end
  // read is combinational so a writeback fits in one cycle
  assign fileRdData = mem[fileAddr];
  always @(posedge clock)
  begin
    if (fileWrEn)
      mem[fileAddr] <= fileWrData;
  end
endmodule : data_mem_model

//--- rtl/alu_core.sv
module alu_core
  import exec_pkg::*;
(
  alu_if.core a
);
  logic [NIB_W:0]  lowSum;
  logic [DATA_W:0] fullSum;
  logic            cin;

  // shared adder; carry in only for the carry-chained add
  always_comb
  begin
    cin     = (a.op == OP_ADDC) ? a.carryIn : 1'b0;
    lowSum  = {1'b0, a.wreg[NIB_MSB:0]} + {1'b0, a.fileVal[NIB_MSB:0]} + {{NIB_W{1'b0}}, cin};
    fullSum = {1'b0, a.wreg} + {1'b0, a.fileVal} + {{DATA_W{1'b0}}, cin};
  end

  // result mux per operation
  always_comb
  begin
    a.result   = a.fileVal;
    a.carryOut = a.carryIn;
    a.digitCarryOut = lowSum[NIB_W];                                  // carry out of bit 3
    a.bitValue = a.fileVal[a.bitSel];
    case (a.op)
      OP_ADD, OP_ADDC:
      begin
        a.result   = fullSum[DATA_W-1:0];
        a.carryOut = fullSum[DATA_W];
      end
      OP_ASR:
      begin
        a.result   = {a.fileVal[MSB_POS], a.fileVal[MSB_POS:1]};      // sign kept
        a.carryOut = a.fileVal[0];
      end
      OP_BCLR:
      begin
        a.result           = a.fileVal;
        a.result[a.bitSel] = 1'b0;
      end
      default:
      begin
        a.result = a.fileVal;
      end
    endcase
    a.zeroOut = (a.result == {DATA_W{1'b0}});
  end
endmodule : alu_core

//--- rtl/alu_if.sv
interface alu_if;
  import exec_pkg::*;
  op_e                op;
  logic [DATA_W-1:0]  wreg;
  logic [DATA_W-1:0]  fileVal;
  logic               carryIn;
  logic [BSEL_W-1:0]  bitSel;
  logic [DATA_W-1:0]  result;
  logic               carryOut;
  logic               digitCarryOut;
  logic               zeroOut;
  logic               bitValue;

  modport core (input op, wreg, fileVal, carryIn, bitSel,
                output result, carryOut, digitCarryOut, zeroOut, bitValue);
  modport user (output op, wreg, fileVal, carryIn, bitSel,
                input result, carryOut, digitCarryOut, zeroOut, bitValue);
endinterface : alu_if

//--- rtl/byte_alu_branch_execute.sv
// Overview of operation
// - add working reg and file, dest bit picks
// - add with carry updates all three flags
// - add-with-carry dest 1 writes file location
// - arithmetic shift right, bit0 into carry
// - shift keeps sign, dest bit picks target
// - bit clear zeros one bit, flags untouched
// - tested bit one: next instruction executes
// - tested bit zero: next becomes no-op
// - branch to next address plus signed offset
// - literal branch always takes two cycles
// - branch adds unsigned working reg, flags kept
// - target is address plus one plus W
module byte_alu_branch_execute
  import exec_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic [INSTR_W-1:0] instrWord,
  input  wire logic               instrValid,
  input  wire logic [PC_W-1:0]    pcCurrent,
  input  wire logic [DATA_W-1:0]  fileRdData,
  input  wire logic               wregLoadEn,
  input  wire logic [DATA_W-1:0]  wregLoadData,
  output logic      [FADDR_W-1:0] fileAddr,
  output logic                    fileWrEn,
  output logic      [DATA_W-1:0]  fileWrData,
  output logic      [DATA_W-1:0]  wreg,
  output logic                    carryFlag,
  output logic                    digit_carry_flag,
  output logic                    zeroFlag,
  output logic                    pcLoad,
  output logic      [PC_W-1:0]    pcTarget,
  output logic                    discardNext
);
  exec_state_e        state;
  exec_state_e        next_state;
  op_e                execOp;
  logic               destFile;
  logic [BSEL_W-1:0]  bitSel;
  logic [OFS_W-1:0]   litOffset;
  logic [PC_W-1:0]    pcNext;
  logic [PC_W-1:0]    next_pcTarget;
  logic               isBranch;
  logic               doSkip;
  logic               writesResult;

  alu_if aluBus ();

  alu_core u_alu (
    .a (aluBus)
  );

  // field decode straight off the word so writeback lands in the same cycle
  assign execOp    = (instrValid && state == ST_RUN) ? decode_op(instrWord) : OP_NONE;
  assign destFile  = instrWord[DEST_POS];
  assign bitSel    = instrWord[BSEL_LSB +: BSEL_W];
  assign litOffset = instrWord[OFS_W-1:0];
  assign fileAddr  = instrWord[FADDR_W-1:0];

  assign aluBus.op      = execOp;
  assign aluBus.wreg    = wreg;
  assign aluBus.fileVal = fileRdData;
  assign aluBus.carryIn = carryFlag;
  assign aluBus.bitSel  = bitSel;

  // write strobe is combinational: memory captures it on this same edge,
  // so a back-to-back read of the same location sees the new value
  assign writesResult = (execOp == OP_ADD) || (execOp == OP_ADDC) || (execOp == OP_ASR);
  assign fileWrEn     = (writesResult && destFile) || (execOp == OP_BCLR);
  assign fileWrData   = aluBus.result;

  // branch and skip decisions
  assign isBranch = (execOp == OP_JMPK) || (execOp == OP_JMPW);
  assign doSkip   = (execOp == OP_BTSC) && !aluBus.bitValue;
  assign pcNext   = pcCurrent + PC_STEP;

  always_comb
  begin
    if (execOp == OP_JMPK)
      next_pcTarget = pcNext + {{(PC_W-OFS_W){litOffset[OFS_W-1]}}, litOffset};
    else
      next_pcTarget = pcNext + {{(PC_W-DATA_W){1'b0}}, wreg};             // unsigned W
  end

  // sequencer: a taken skip or branch burns the already fetched word as a no-op
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (isBranch || doSkip)
          next_state = ST_FLUSH;
      end
      ST_FLUSH:
      begin
        next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_RUN;
      end
    endcase
  end

  assign discardNext = (state == ST_FLUSH);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // program counter load pulse, one cycle after the branch
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pcLoad   <= 1'b0;
      pcTarget <= PC_RESET;
    end
    else
    begin
      pcLoad <= isBranch;
      if (isBranch)
        pcTarget <= next_pcTarget;
    end
  end

  // working register: execution result wins over the core's own load path
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      wreg <= WREG_RESET;
    else if (writesResult && !destFile)
      wreg <= aluBus.result;
    else if (wregLoadEn)
      wreg <= wregLoadData;
  end

  // status flags; bit ops and branches leave them alone
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      carryFlag        <= 1'b0;
      digit_carry_flag <= 1'b0;
      zeroFlag         <= 1'b0;
    end
    else
    begin
      if (writesResult)
      begin
        carryFlag <= aluBus.carryOut;
        zeroFlag  <= aluBus.zeroOut;
      end
      if (execOp == OP_ADD || execOp == OP_ADDC)
        digit_carry_flag <= aluBus.digitCarryOut;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  addToWreg_a: assert property (execOp == OP_ADD && !destFile |=>
      wreg == $past(wreg) + $past(fileRdData)) else $error("add to working reg wrong");
  addcToFile_a: assert property (execOp == OP_ADDC && destFile |->
      fileWrEn && fileWrData == DATA_W'(wreg + fileRdData + {7'h00, carryFlag}))
      else $error("add with carry file write wrong");
  addcCarry_a: assert property (execOp == OP_ADDC |=>
      carryFlag == $past(9'({1'b0, wreg} + {1'b0, fileRdData} + {8'h00, carryFlag}) > 9'h0FF) &&
      digit_carry_flag == $past((5'(wreg[3:0]) + 5'(fileRdData[3:0]) + 5'(carryFlag)) > 5'h0F))
      else $error("add with carry flags wrong");
  asrShape_a: assert property (execOp == OP_ASR |->
      aluBus.result[MSB_POS] == fileRdData[MSB_POS] && aluBus.result[MSB_POS-1:0] == fileRdData[MSB_POS:1])
      else $error("shift result wrong");
  asrCarry_a: assert property (execOp == OP_ASR |=>
      carryFlag == $past(fileRdData[0])) else $error("shift carry wrong");
  bitClear_a: assert property (execOp == OP_BCLR |-> fileWrEn && !fileWrData[bitSel] ##1
      $stable(carryFlag) && $stable(zeroFlag) && $stable(digit_carry_flag))
      else $error("bit clear wrong");
  skipClear_a: assert property (execOp == OP_BTSC && !fileRdData[bitSel] |=>
      discardNext ##1 !discardNext) else $error("skip did not discard one word");
  noSkipSet_a: assert property (execOp == OP_BTSC && fileRdData[bitSel] |=>
      !discardNext && $stable(zeroFlag) && $stable(carryFlag)) else $error("skip taken on set bit");
  litBranch_a: assert property (execOp == OP_JMPK |=> pcLoad && discardNext &&
      pcTarget == PC_W'($past(pcCurrent) + PC_STEP + {{6{$past(instrWord[8])}}, $past(instrWord[8:0])}))
      else $error("literal branch target wrong");
  wregBranch_a: assert property (execOp == OP_JMPW |=> pcLoad &&
      pcTarget == PC_W'($past(pcCurrent) + PC_STEP + {7'h00, $past(wreg)}) && $stable(carryFlag))
      else $error("working reg branch target wrong");
  addZero_a: assert property (execOp == OP_ADD |=>
      zeroFlag == ($past(fileWrData) == 8'h00)) else $error("zero flag wrong");
endmodule : byte_alu_branch_execute

//--- rtl/exec_pkg.sv
package exec_pkg;
  // datapath widths
  localparam int PC_W    = 15;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int INSTR_W = 14;
  localparam int BSEL_W  = 3;
  localparam int OFS_W   = 9;
  localparam int NIB_W   = 4;

  // field positions inside the instruction word and the data byte
  localparam int DEST_POS  = 7;
  localparam int BSEL_LSB  = 7;
  localparam int MSB_POS   = DATA_W - 1;
  localparam int NIB_MSB   = NIB_W - 1;

  // opcode patterns and the masks that select their fixed bits
  localparam logic [INSTR_W-1:0] MASK_BYTE = 14'h3F00;
  localparam logic [INSTR_W-1:0] MASK_BIT  = 14'h3C00;
  localparam logic [INSTR_W-1:0] MASK_JMPK = 14'h3E00;
  localparam logic [INSTR_W-1:0] MASK_FULL = 14'h3FFF;
  localparam logic [INSTR_W-1:0] OPC_ADD   = 14'h0700;
  localparam logic [INSTR_W-1:0] OPC_ADDC  = 14'h3D00;
  localparam logic [INSTR_W-1:0] OPC_ASR   = 14'h3700;
  localparam logic [INSTR_W-1:0] OPC_BCLR  = 14'h1000;
  localparam logic [INSTR_W-1:0] OPC_BTSC  = 14'h1800;
  localparam logic [INSTR_W-1:0] OPC_JMPK  = 14'h3200;
  localparam logic [INSTR_W-1:0] OPC_JMPW  = 14'h000B;

  // reset values and the program counter step
  localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET   = 15'h0000;
  localparam logic [PC_W-1:0]   PC_STEP    = 15'h0001;

  // one-hot operation codes
  typedef enum logic [7:0] {
    OP_NONE  = 8'h01,
    OP_ADD   = 8'h02,
    OP_ADDC  = 8'h04,
    OP_ASR   = 8'h08,
    OP_BCLR  = 8'h10,
    OP_BTSC  = 8'h20,
    OP_JMPK  = 8'h40,
    OP_JMPW  = 8'h80
  } op_e;

  // execute sequencer: normal issue, or discard the prefetched word
  typedef enum logic [1:0] {
    ST_RUN   = 2'h1,
    ST_FLUSH = 2'h2
  } exec_state_e;

  function automatic op_e decode_op(input logic [INSTR_W-1:0] iw);
    if ((iw & MASK_BYTE) == OPC_ADD)
      return OP_ADD;
    else if ((iw & MASK_BYTE) == OPC_ADDC)
      return OP_ADDC;
    else if ((iw & MASK_BYTE) == OPC_ASR)
      return OP_ASR;
    else if ((iw & MASK_BIT) == OPC_BCLR)
      return OP_BCLR;
    else if ((iw & MASK_BIT) == OPC_BTSC)
      return OP_BTSC;
    else if ((iw & MASK_JMPK) == OPC_JMPK)
      return OP_JMPK;
    else if ((iw & MASK_FULL) == OPC_JMPW)
      return OP_JMPW;
    else
      return OP_NONE;
  endfunction : decode_op
endpackage : exec_pkg
